// *** core/edmi_core.sv ***
// Multiplexed external data memory interface with on-chip data space routing
//
// The register addresses and the strobed register port were decided locally.
`timescale 1ns/100ps
`default_nettype none
module edmi_core
	import edmi_pkg::*;
(
	input wire logic ref_clk,
	input wire logic rst_n,
	// Register port
	input wire logic [1:0] regAddr,
	input wire logic [7:0] regWdata,
	input wire logic regWr,
	input wire logic regRd,
	output logic [7:0] regRdata,
	// Move request from the core
	input wire logic movReq,
	input wire logic movWrite,
	input wire logic mov16,
	input wire logic [7:0] movIndex,
	input wire logic [15:0] movPointer,
	input wire logic [7:0] movWdata,
	output logic movDone,
	output logic [7:0] movRdata,
	// On-chip data space RAM, read data one cycle after enable
	output logic ramEn,
	output logic ramWe,
	output logic [11:0] ramAddr,
	output logic [7:0] ramWdata,
	input wire logic [7:0] ramRdata,
	// Port output mode per pin group: 1 push-pull, 0 open-drain
	input wire logic pushPullAd,
	input wire logic pushPullHi,
	input wire logic pushPullCtl,
	// Pins; pinClaim selects this block over the port latches
	output logic pinClaim,
	input wire logic [7:0] adIn,
	output logic [7:0] adOut,
	output logic [7:0] adOe,
	output logic [3:0] addrHiOut,
	output logic [3:0] addrHiOe,
	output logic aleOut,
	output logic aleOe,
	output logic rdNOut,
	output logic rdNOe,
	output logic wrNOut,
	output logic wrNOe
);
	logic [7:0] page_r;
	logic [3:0] mode_r;
	logic [7:0] timing_r;
	logic [1:0] mapMode;
	logic [1:0] aleCode;
	logic [1:0] setupCode;
	logic [3:0] strobeCode;
	logic [1:0] holdCode;
	logic busy;
	logic lastOff_r;
	edmi_state_e state_r;
	edmi_state_e state_nxt;
	logic cntLoad;
	logic [CNT_W-1:0] cntVal;
	logic cntZero;
	logic [3:0] tail_r;
	logic [7:0] adSync;
	logic goOff;
	logic [15:0] effAddr;
	logic hiDrive;
	logic wr_r;
	logic hiDrive_r;
	logic [11:0] extAddr_r;
	logic [7:0] wdata_r;
	logic ramPend_r;
	logic claim;
	logic adIsOut;
	logic [7:0] adVal;
	logic aleVal;
	logic rdVal;
	logic wrVal;

	assign mapMode = mode_r[MODE_MAP_LSB +: 2];
	assign aleCode = mode_r[MODE_ALE_LSB +: 2];
	assign setupCode = timing_r[TIM_SETUP_LSB +: 2];
	assign strobeCode = timing_r[TIM_STROBE_LSB +: 4];
	assign holdCode = timing_r[TIM_HOLD_LSB +: 2];
	assign busy = (state_r != ST_IDLE);

	// Register writes; timing fields reset to their largest delays
	always_ff @(posedge ref_clk)
	begin
		if (!rst_n)
		begin
			page_r <= PAGE_RST;
			mode_r <= MODE_RST;
			timing_r <= TIMING_RST;
		end
		else if (regWr)
		begin
			unique case (regAddr)
				REG_PAGE: page_r <= {3'h0, regWdata[PAGE_MSB:0]};
				REG_MODE: mode_r <= regWdata[3:0];
				REG_TIMING: timing_r <= regWdata;
				default: ;
			endcase
		end
	end

	// Register reads, answered in the following cycle; unused bits read zero
	always_ff @(posedge ref_clk)
	begin
		if (!rst_n)
			regRdata <= 8'h00;
		else if (regRd)
		begin
			unique case (regAddr)
				REG_PAGE: regRdata <= page_r;
				REG_MODE: regRdata <= {4'h0, mode_r};
				REG_TIMING: regRdata <= timing_r;
				REG_STATUS: regRdata <= {6'h00, lastOff_r, busy};
			endcase
		end
		else
			regRdata <= 8'h00;
	end

	// Effective address from page and index, or from the data pointer
	always_comb
	begin
		if (mov16)
			effAddr = movPointer;
		else
			effAddr = {page_r, movIndex};
	end

	// On-chip or off-chip decision per memory map mode
	always_comb
	begin
		unique case (mapMode)
			MAP_INTERNAL: goOff = 1'b0;
			MAP_SPLIT_NOBANK, MAP_SPLIT_BANK:
			begin
				if (mov16)
					goOff = (effAddr >= 16'(ONCHIP_BYTES));
				else
					goOff = page_r[PAGE_OFF_BIT];
			end
			MAP_EXTERNAL: goOff = 1'b1;
		endcase
	end

	// Upper address pins: driven for 16-bit moves and for banked 8-bit moves only
	always_comb
	begin
		if (mov16)
			hiDrive = 1'b1;
		else
			hiDrive = (mapMode == MAP_SPLIT_BANK);
	end

	// Sequencer: next state and phase counter loads
	always_comb
	begin
		state_nxt = state_r;
		cntLoad = 1'b0;
		cntVal = '0;
		unique case (state_r)
			ST_IDLE:
			begin
				if (movReq)
					state_nxt = goOff ? ST_START : ST_ONCHIP;
			end
			ST_ONCHIP:
				state_nxt = ST_IDLE;
			ST_START:
			begin
				state_nxt = ST_ALEHI;
				cntLoad = 1'b1;
				cntVal = CNT_W'(aleCode);
			end
			ST_ALEHI:
			begin
				if (cntZero)
				begin
					state_nxt = ST_ALELO;
					cntLoad = 1'b1;
					cntVal = CNT_W'(aleCode);
				end
			end
			ST_ALELO:
			begin
				if (cntZero)
				begin
					cntLoad = 1'b1;
					if (setupCode != 2'h0)
					begin
						state_nxt = ST_SETUP;
						cntVal = CNT_W'(setupCode - 2'h1);
					end
					else
					begin
						state_nxt = ST_STROBE;
						cntVal = strobeCode;
					end
				end
			end
			ST_SETUP:
			begin
				if (cntZero)
				begin
					state_nxt = ST_STROBE;
					cntLoad = 1'b1;
					cntVal = strobeCode;
				end
			end
			ST_STROBE:
			begin
				if (cntZero)
				begin
					state_nxt = ST_TAIL;
					cntLoad = 1'b1;
					cntVal = CNT_W'(holdCode) + TAIL_CYCLES - 4'h1;
				end
			end
			ST_TAIL:
			begin
				if (cntZero)
					state_nxt = ST_IDLE;
			end
		endcase
	end

	// State register
	always_ff @(posedge ref_clk)
	begin
		if (!rst_n)
			state_r <= ST_IDLE;
		else
			state_r <= state_nxt;
	end

	edmi_phase_cnt #(
		.W(CNT_W)
	) u_phase (
		.ref_clk(ref_clk),
		.rst_n(rst_n),
		.load(cntLoad),
		.loadVal(cntVal),
		.zero(cntZero)
	);

	edmi_sync2 #(
		.W(8)
	) u_adsync (
		.ref_clk(ref_clk),
		.rst_n(rst_n),
		.asyncIn(adIn),
		.syncOut(adSync)
	);

	// Capture request details once, so the core may change them mid access
	always_ff @(posedge ref_clk)
	begin
		if (!rst_n)
		begin
			wr_r <= 1'b0;
			hiDrive_r <= 1'b0;
			extAddr_r <= 12'h000;
			wdata_r <= 8'h00;
			lastOff_r <= 1'b0;
		end
		else if ((state_r == ST_IDLE) && movReq)
		begin
			wr_r <= movWrite;
			hiDrive_r <= hiDrive;
			extAddr_r <= effAddr[ONCHIP_AW-1:0];
			wdata_r <= movWdata;
			lastOff_r <= goOff;
		end
	end

	// Tail cycle index, used to pick the synchronised read data
	always_ff @(posedge ref_clk)
	begin
		if (!rst_n)
			tail_r <= 4'h0;
		else if (state_r == ST_TAIL)
			tail_r <= tail_r + 4'h1;
		else
			tail_r <= 4'h0;
	end

	// On-chip access; the address wraps within the 4096-byte space
	always_ff @(posedge ref_clk)
	begin
		if (!rst_n)
		begin
			ramEn <= 1'b0;
			ramWe <= 1'b0;
			ramAddr <= 12'h000;
			ramWdata <= 8'h00;
		end
		else
		begin
			ramEn <= (state_r == ST_IDLE) && movReq && !goOff;
			ramWe <= (state_r == ST_IDLE) && movReq && !goOff && movWrite;
			ramAddr <= effAddr[ONCHIP_AW-1:0];
			ramWdata <= movWdata;
		end
	end

	// Pending on-chip read completes one cycle after the RAM enable
	always_ff @(posedge ref_clk)
	begin
		if (!rst_n)
			ramPend_r <= 1'b0;
		else
			ramPend_r <= ramEn;
	end

	// Move completion and read data; synchronised pins lag two clocks
	always_ff @(posedge ref_clk)
	begin
		if (!rst_n)
		begin
			movDone <= 1'b0;
			movRdata <= 8'h00;
		end
		else
		begin
			movDone <= ramPend_r || ((state_r == ST_TAIL) && cntZero);
			if (ramPend_r && !wr_r)
				movRdata <= ramRdata;
			else if ((state_r == ST_TAIL) && (tail_r == TAIL_SAMPLE) && !wr_r)
				movRdata <= adSync;
		end
	end

	// Pin values by phase; the shared lines carry address then data
	always_comb
	begin
		claim = (state_r != ST_IDLE) && (state_r != ST_ONCHIP);
		aleVal = (state_r == ST_ALEHI);
		rdVal = !((state_r == ST_STROBE) && !wr_r);
		wrVal = !((state_r == ST_STROBE) && wr_r);
		if ((state_r == ST_START) || (state_r == ST_ALEHI) || (state_r == ST_ALELO))
		begin
			adIsOut = 1'b1;
			adVal = extAddr_r[7:0];
		end
		else
		begin
			adIsOut = wr_r && ((state_r == ST_SETUP) || (state_r == ST_STROBE)
				|| ((state_r == ST_TAIL) && (tail_r < 4'(holdCode))));
			adVal = wdata_r;
		end
	end

	// Registered pins; drivers follow pin mode, and are off for inputs or when released
	always_ff @(posedge ref_clk)
	begin
		if (!rst_n)
		begin
			pinClaim <= 1'b0;
			adOut <= 8'h00;
			adOe <= 8'h00;
			addrHiOut <= 4'h0;
			addrHiOe <= 4'h0;
			aleOut <= 1'b0;
			aleOe <= 1'b0;
			rdNOut <= 1'b1;
			rdNOe <= 1'b0;
			wrNOut <= 1'b1;
			wrNOe <= 1'b0;
		end
		else
		begin
			pinClaim <= claim;
			adOut <= adVal;
			adOe <= (claim && adIsOut) ? (pushPullAd ? 8'hff : ~adVal) : 8'h00;
			addrHiOut <= extAddr_r[11:8];
			addrHiOe <= (claim && hiDrive_r) ? (pushPullHi ? 4'hf : ~extAddr_r[11:8]) : 4'h0;
			aleOut <= aleVal;
			aleOe <= claim && (pushPullCtl || !aleVal);
			rdNOut <= rdVal;
			rdNOe <= claim && (pushPullCtl || !rdVal);
			wrNOut <= wrVal;
			wrNOe <= claim && (pushPullCtl || !wrVal);
		end
	end
endmodule // edmi_core
`default_nettype wire

// *** core/edmi_pkg.sv ***
// Package with register map, field layout, reset values and states of the external memory interface
package edmi_pkg;
	// Register indices on the plain register port
	localparam logic [1:0] REG_PAGE = 2'h0;
	localparam logic [1:0] REG_MODE = 2'h1;
	localparam logic [1:0] REG_TIMING = 2'h2;
	localparam logic [1:0] REG_STATUS = 2'h3;
	// Reset values: latch strobe width and all timing fields at their largest settings
	localparam logic [7:0] PAGE_RST = 8'h00;
	localparam logic [3:0] MODE_RST = 4'h3;
	localparam logic [7:0] TIMING_RST = 8'hff;
	// Field positions
	localparam int PAGE_MSB = 4;
	localparam int PAGE_OFF_BIT = 4;
	localparam int MODE_MAP_LSB = 2;
	localparam int MODE_ALE_LSB = 0;
	localparam int TIM_SETUP_LSB = 6;
	localparam int TIM_STROBE_LSB = 2;
	localparam int TIM_HOLD_LSB = 0;
	// Memory map modes
	localparam logic [1:0] MAP_INTERNAL = 2'h0;
	localparam logic [1:0] MAP_SPLIT_NOBANK = 2'h1;
	localparam logic [1:0] MAP_SPLIT_BANK = 2'h2;
	localparam logic [1:0] MAP_EXTERNAL = 2'h3;
	// On-chip data space is 4096 bytes, so twelve address bits reach it
	localparam int ONCHIP_BYTES = 4096;
	localparam int ONCHIP_AW = $clog2(ONCHIP_BYTES);
	// Fixed overhead of an off-chip access: one start cycle and three tail cycles
	localparam logic [3:0] TAIL_CYCLES = 4'h3;
	// Third tail cycle: the synchroniser then holds the last strobe-low pin value
	localparam logic [3:0] TAIL_SAMPLE = 4'h2;
	localparam int CNT_W = 4;
	// Access sequencer states
	typedef enum logic [2:0] {
		ST_IDLE = 3'b000,
		ST_ONCHIP = 3'b001,
		ST_START = 3'b010,
		ST_ALEHI = 3'b011,
		ST_ALELO = 3'b100,
		ST_SETUP = 3'b101,
		ST_STROBE = 3'b110,
		ST_TAIL = 3'b111
	} edmi_state_e;
endpackage

// *** core/edmi_sync2.sv ***
// Two-flop synchroniser for a group of pin inputs
`timescale 1ns/100ps
`default_nettype none
module edmi_sync2 #(
	parameter int W = 8
) (
	input wire logic ref_clk,
	input wire logic rst_n,
	input wire logic [W-1:0] asyncIn,
	output logic [W-1:0] syncOut
);
	logic [W-1:0] meta_r;

	// First stage feeds only the second stage
	always_ff @(posedge ref_clk)
	begin
		if (!rst_n)
		begin
			meta_r <= '0;
			syncOut <= '0;
		end
		else
		begin
			meta_r <= asyncIn;
			syncOut <= meta_r;
		end
	end
endmodule // edmi_sync2
`default_nettype wire

// *** core/edmi_phase_cnt.sv ***
// Loadable down counter that times one phase of a bus access
`timescale 1ns/100ps
`default_nettype none
module edmi_phase_cnt #(
	parameter int W = 4
) (
	input wire logic ref_clk,
	input wire logic rst_n,
	input wire logic load,
	input wire logic [W-1:0] loadVal,
	output logic zero
);
	logic [W-1:0] cnt_r;

	// Load wins over counting so a new phase always starts clean
	always_ff @(posedge ref_clk)
	begin
		if (!rst_n)
			cnt_r <= '0;
		else if (load)
			cnt_r <= loadVal;
		else if (cnt_r != '0)
			cnt_r <= cnt_r - 1'b1;
	end

	assign zero = (cnt_r == '0);
endmodule // edmi_phase_cnt
`default_nettype wire

// *** test/edmi_core_asserts.sv ***
// Checker on the pin side of the external memory interface
`timescale 1ns/100ps
`default_nettype none
module edmi_core_asserts (
	input wire logic ref_clk,
	input wire logic rst_n,
	input wire logic pushPullAd,
	input wire logic pushPullHi,
	input wire logic movDone,
	input wire logic ramEn,
	input wire logic pinClaim,
	input wire logic [7:0] adOut,
	input wire logic [7:0] adOe,
	input wire logic [3:0] addrHiOut,
	input wire logic [3:0] addrHiOe,
	input wire logic aleOut,
	input wire logic aleOe,
	input wire logic rdNOut,
	input wire logic rdNOe,
	input wire logic wrNOut,
	input wire logic wrNOe
);
	default clocking @(posedge ref_clk);
	endclocking
	default disable iff (!rst_n);
	// Latches own the pins, so no enable may leak out
	chk_claim_free: assert property (
		!pinClaim |-> adOe == 8'h00 && addrHiOe == 4'h0 && !aleOe && !rdNOe && !wrNOe)
		else $error("enable while released");
	chk_release_done: assert property (
		$fell(pinClaim) |-> $past(movDone))
		else $error("release without done");
	chk_read_input: assert property (
		!rdNOut |-> adOe == 8'h00)
		else $error("bus driven during read");
	// Open-drain pins may only pull low
	chk_od_bus: assert property (
		!pushPullAd |-> (adOe & adOut) == 8'h00)
		else $error("open-drain bus drives high");
	chk_od_upper: assert property (
		!pushPullHi |-> (addrHiOe & addrHiOut) == 4'h0)
		else $error("open-drain upper drives high");
	chk_ale_addr: assert property (
		aleOut && pushPullAd |-> adOe == 8'hff)
		else $error("address not driven under latch strobe");
	chk_ale_hold: assert property (
		$fell(aleOut) |-> $stable(adOut) && $stable(adOe))
		else $error("address moved at strobe fall");
	chk_write_drive: assert property (
		!wrNOut && pushPullAd |-> adOe == 8'hff)
		else $error("data not driven under write");
	chk_strobe_one: assert property (
		rdNOut || wrNOut)
		else $error("both strobes low");
	chk_strobe_idle: assert property (
		!pinClaim |-> rdNOut && wrNOut)
		else $error("strobe low while released");
	// Shortest multiplexed access keeps the pins seven clocks
	chk_claim_min: assert property (
		$rose(pinClaim) |-> pinClaim [*7])
		else $error("access too short");
	cover property ($fell(wrNOut));
	cover property ($fell(rdNOut));
	cover property (ramEn);
endmodule // edmi_core_asserts
`default_nettype wire

// *** test/edmi_sram_model.sv ***
// Address latch and SRAM on the far side of the multiplexed bus
`timescale 1ns/100ps
`default_nettype none
module edmi_sram_model (
	input wire logic ref_clk,
	input wire logic pinClaim,
	input wire logic [7:0] adOut,
	input wire logic [7:0] adOe,
	input wire logic [3:0] addrHiOut,
	input wire logic [3:0] addrHiOe,
	input wire logic aleOut,
	input wire logic rdNOut,
	input wire logic wrNOut,
	output logic [7:0] adIn,
	output logic [11:0] lastAddr,
	output logic hiSeen
);
	logic [7:0] mem [0:4095];
	logic [7:0] latchLo;
	logic [3:0] hiPin;
	// Undriven upper pins sit at the parked latch level
	assign hiPin = ~addrHiOe | addrHiOut;
	// Released lines float to the parked latch level; only the read strobe lets memory drive them
	assign adIn = (adOe & adOut) | (~adOe & (!rdNOut ? mem[{hiPin, latchLo}] : 8'hff));
	// Latch, memory and observation of each access
	always @(posedge ref_clk)
	begin
		if (aleOut)
			latchLo <= adIn;
		if (!wrNOut)
			mem[{hiPin, latchLo}] <= adIn;
		if (!rdNOut || !wrNOut)
			lastAddr <= {hiPin, latchLo};
		if (!pinClaim)
			hiSeen <= 1'b0;
		else if (|addrHiOe)
			hiSeen <= 1'b1;
	end
endmodule // edmi_sram_model
`default_nettype wire

// *** test/edmi_tb.sv ***
// Testbench for the external memory interface
`timescale 1ns/100ps
`default_nettype none
module tb;
	logic ref_clk = 1'b0;
	logic rst_n = 1'b0;
	logic [1:0] regAddr = 2'h0;
	logic [7:0] regWdata = 8'h00;
	logic regWr = 1'b0;
	logic regRd = 1'b0;
	logic movReq = 1'b0;
	logic movWrite = 1'b0;
	logic mov16 = 1'b0;
	logic [7:0] movIndex = 8'h00;
	logic [15:0] movPointer = 16'h0000;
	logic [7:0] movWdata = 8'h00;
	logic [7:0] ramRdata = 8'h00;
	logic pushPullAd = 1'b1;
	logic pushPullHi = 1'b1;
	logic pushPullCtl = 1'b1;
	logic [7:0] regRdata, movRdata, ramWdata, adIn, adOut, adOe;
	logic [11:0] ramAddr, lastRam, lastAddr;
	logic [8:0] lastRamW;
	logic [3:0] addrHiOut, addrHiOe;
	logic movDone, ramEn, ramWe, pinClaim, aleOut, aleOe, rdNOut, rdNOe, wrNOut, wrNOe, hiSeen;
	int bad_count = 0;
	int n_tests = 0;
	edmi_core dut_u (.ref_clk(ref_clk), .rst_n(rst_n), .regAddr(regAddr), .regWdata(regWdata),
		.regWr(regWr), .regRd(regRd), .regRdata(regRdata), .movReq(movReq), .movWrite(movWrite),
		.mov16(mov16), .movIndex(movIndex), .movPointer(movPointer), .movWdata(movWdata),
		.movDone(movDone), .movRdata(movRdata), .ramEn(ramEn), .ramWe(ramWe), .ramAddr(ramAddr),
		.ramWdata(ramWdata), .ramRdata(ramRdata), .pushPullAd(pushPullAd), .pushPullHi(pushPullHi),
		.pushPullCtl(pushPullCtl), .pinClaim(pinClaim), .adIn(adIn), .adOut(adOut), .adOe(adOe),
		.addrHiOut(addrHiOut), .addrHiOe(addrHiOe), .aleOut(aleOut), .aleOe(aleOe),
		.rdNOut(rdNOut), .rdNOe(rdNOe), .wrNOut(wrNOut), .wrNOe(wrNOe));
	edmi_sram_model ext_u (.ref_clk(ref_clk), .pinClaim(pinClaim), .adOut(adOut), .adOe(adOe),
		.addrHiOut(addrHiOut), .addrHiOe(addrHiOe), .aleOut(aleOut), .rdNOut(rdNOut),
		.wrNOut(wrNOut), .adIn(adIn), .lastAddr(lastAddr), .hiSeen(hiSeen));
	initial
		forever #20 ref_clk = ~ref_clk;
	// On-chip RAM: data a cycle after enable, address remembered for checks
	always @(posedge ref_clk)
	begin
		if (ramEn)
		begin
			ramRdata <= ramAddr[7:0] ^ 8'h5a;
			lastRam <= ramAddr;
			lastRamW <= {ramWe, ramWdata};
		end
	end
	task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
		n_tests++;
		if (got !== exp)
		begin
			bad_count++;
			$display("BAD %0t got %h want %h", $time, got, exp);
		end
	endtask
	task automatic wr(input logic [1:0] a, input logic [7:0] d);
		@(posedge ref_clk);
		regWr <= 1'b1;
		regAddr <= a;
		regWdata <= d;
		@(posedge ref_clk);
		regWr <= 1'b0;
	endtask
	task automatic rdc(input logic [1:0] a, input logic [7:0] exp);
		@(posedge ref_clk);
		regRd <= 1'b1;
		regAddr <= a;
		@(posedge ref_clk);
		regRd <= 1'b0;
		#1 cmp(regRdata, exp);
	endtask
	// One move; checks the cycle of done and, for reads, the data
	task automatic mov(input logic w, input logic b16, input logic [7:0] idx, input logic [15:0] ptr,
		input logic [7:0] d, input int expK);
		int k;
		k = 0;
		@(posedge ref_clk);
		movReq <= 1'b1;
		movWrite <= w;
		mov16 <= b16;
		movIndex <= idx;
		movPointer <= ptr;
		movWdata <= d;
		do
		begin
			@(posedge ref_clk);
			movReq <= 1'b0;
			k++;
			#1;
		end
		while (movDone !== 1'b1 && k < 60);
		cmp(16'(k), 16'(expK));
		if (!w)
			cmp(movRdata, d);
	endtask
	task automatic print_verdict;
		$display("checks %0d mismatches %0d", n_tests, bad_count);
		if (bad_count == 0 && n_tests > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	task automatic t_regs;
		rdc(2'h2, 8'hff);
		wr(2'h0, 8'hff);
		rdc(2'h0, 8'h1f);
		rdc(2'h3, 8'h00);
		$display("regs done");
	endtask
	task automatic t_onchip;
		mov(1'b1, 1'b0, 8'h3c, 16'h0000, 8'h11, 3);
		cmp(lastRam, 12'hf3c);
		cmp(lastRamW, 9'h111);
		mov(1'b0, 1'b1, 8'h00, 16'h1234, 8'h6e, 3);
		cmp(lastRam, 12'h234);
		cmp(lastRamW, 9'h06e);
		$display("onchip done");
	endtask
	task automatic t_slow;
		wr(2'h1, 8'h0f);
		mov(1'b1, 1'b0, 8'h22, 16'h0000, 8'h44, 35);
		cmp(lastAddr, 12'hf22);
		rdc(2'h3, 8'h02);
		cmp(hiSeen, 1'b0);
		$display("default timing done");
	endtask
	task automatic t_bank;
		wr(2'h2, 8'h00);
		wr(2'h1, 8'h08);
		wr(2'h0, 8'h15);
		mov(1'b1, 1'b0, 8'h3c, 16'h0000, 8'ha7, 8);
		cmp(lastAddr, 12'h53c);
		cmp(hiSeen, 1'b1);
		mov(1'b0, 1'b0, 8'h3c, 16'h0000, 8'ha7, 8);
		wr(2'h0, 8'h05);
		mov(1'b1, 1'b0, 8'h3c, 16'h0000, 8'h01, 3);
		cmp(lastRam, 12'h53c);
		$display("bank done");
	endtask
	task automatic t_nobank;
		wr(2'h1, 8'h04);
		wr(2'h0, 8'h12);
		mov(1'b1, 1'b0, 8'h40, 16'h0000, 8'h3e, 8);
		cmp(lastAddr, 12'hf40);
		cmp(hiSeen, 1'b0);
		mov(1'b0, 1'b1, 8'h00, 16'h0800, 8'h5a, 3);
		cmp(lastRam, 12'h800);
		mov(1'b1, 1'b1, 8'h00, 16'h1abc, 8'h99, 8);
		cmp(lastAddr, 12'habc);
		cmp(hiSeen, 1'b1);
		mov(1'b0, 1'b1, 8'h00, 16'h1abc, 8'h99, 8);
		$display("nobank done");
	endtask
	task automatic t_ext;
		wr(2'h1, 8'h0c);
		wr(2'h0, 8'h01);
		mov(1'b1, 1'b1, 8'h00, 16'h0345, 8'h5c, 8);
		cmp(lastAddr, 12'h345);
		cmp(hiSeen, 1'b1);
		mov(1'b0, 1'b0, 8'h22, 16'h0000, 8'h44, 8);
		cmp(hiSeen, 1'b0);
		$display("external done");
	endtask
	task automatic t_timing;
		wr(2'h1, 8'h0f);
		wr(2'h2, 8'h8d);
		pushPullAd <= 1'b0;
		pushPullHi <= 1'b0;
		pushPullCtl <= 1'b0;
		mov(1'b0, 1'b1, 8'h00, 16'h0345, 8'h5c, 20);
		@(posedge ref_clk);
		pushPullAd <= 1'b1;
		pushPullHi <= 1'b1;
		pushPullCtl <= 1'b1;
		$display("timing done");
	endtask
	initial
	begin
		repeat (10) @(posedge ref_clk);
		rst_n <= 1'b1;
		t_regs();
		t_onchip();
		t_slow();
		t_bank();
		t_nobank();
		t_ext();
		t_timing();
		print_verdict();
	end
	// Whole run is under two hundred clocks
	initial
	begin
		repeat (5000) @(posedge ref_clk);
		bad_count++;
		print_verdict();
	end
endmodule // tb
bind edmi_core edmi_core_asserts chk_u (.ref_clk(ref_clk), .rst_n(rst_n), .pushPullAd(pushPullAd),
	.pushPullHi(pushPullHi), .movDone(movDone), .ramEn(ramEn), .pinClaim(pinClaim), .adOut(adOut),
	.adOe(adOe), .addrHiOut(addrHiOut), .addrHiOe(addrHiOe), .aleOut(aleOut), .aleOe(aleOe),
	.rdNOut(rdNOut), .rdNOe(rdNOe), .wrNOut(wrNOut), .wrNOe(wrNOe));
`default_nettype wire
